// ---- pkg/clk_ctrl_params.svh ----
// Offsets, field positions and reset values of the clock control registers
`ifndef CLK_CTRL_PARAMS_SVH
`define CLK_CTRL_PARAMS_SVH

// Register byte offsets
`define CTRL_OFS        4'h0
`define STATUS_OFS      4'h4

// Control word field positions
`define KIND_LSB        0
`define LEFT_BIT        2
`define DYNSEL_BIT      3
`define SSEL_LSB        4
`define IN2_PICK_BIT    6
`define IN3_PICK_BIT    7
`define INUSE_BIT       8
`define SENA_BIT        9
`define DYNENA_BIT      10
`define BYPASS_BIT      11
`define DRVPLL_BIT      12
`define DUAL_BIT        13
`define PSRC_BIT        14
`define EXTEN_LSB       15
`define PIN0_LSB        17
`define PIN1_LSB        19

// Writable bits and reset value: in use, static enable, both external outputs, pin 1 on input 1
`define CTRL_MASK       32'h001F_FFFF
`define CTRL_RESET      32'h0009_8300

// Reset value of the captured enable: network starts running
`define ENA_RESET       1'h1

// Status word field positions
`define ST_SEL_LSB      0
`define ST_ENA_BIT      2
`define ST_ACTIVE_BIT   3
`define ST_LEVEL_BIT    4
`define ST_DYNSEL_BIT   5
`define ST_DYNENA_BIT   6

`endif

// ---- pkg/clk_ctrl_pkg.sv ----
// Types shared by the clock control block
`default_nettype none
package clk_ctrl_pkg;
  typedef enum logic [1:0] {
    KIND_GLOBAL   = 2'b00,
    KIND_REGIONAL = 2'b01,
    KIND_PERIPH   = 2'b10,
    KIND_RSVD     = 2'b11
  } net_kind_t;
  typedef logic [31:0] word_t;
  typedef logic [3:0]  reg_addr_t;
  typedef logic [1:0]  mux_sel_t;
endpackage : clk_ctrl_pkg
`default_nettype wire

// ---- pkg/net_ctrl_if.sv ----
// Interface between the control top, the source mux and the gate
`timescale 1ns/10ps
`default_nettype none
interface net_ctrl_if;
  import clk_ctrl_pkg::*;
  logic [3:0] inclk;
  mux_sel_t   sel;
  logic       src_clk;
  logic       ena_req;
  logic       bypass;
  logic       gating_ok;
  logic       power_down;
  logic       gated_clk;
  logic       ena_state;
  modport sel_side  (input inclk, input sel, output src_clk);
  modport gate_side (input src_clk, input ena_req, input bypass, input gating_ok,
                     input power_down, output gated_clk, output ena_state);
  modport ctrl      (output inclk, output sel, output ena_req, output bypass,
                     output gating_ok, output power_down,
                     input src_clk, input gated_clk, input ena_state);
endinterface : net_ctrl_if
`default_nettype wire

// ---- rtl/clk_source_mux.sv ----
// Four-input network source multiplexer
`timescale 1ns/10ps
`default_nettype none
module clk_source_mux (
  input  wire logic        core_clk, // Core clock
  input  wire logic        rst_b,    // Async reset, active low
  net_ctrl_if.sel_side     nc        // Mux inputs, select and result
);
  import clk_ctrl_pkg::*;

  logic picked;

  // Pick by index; pins sit on 0 and 1, counters on 2 and 3, except on periphery; left blocks hold 3 low
  assign picked = nc.inclk[nc.sel];

  // Registered so the selected level is glitch free for the gate
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      nc.src_clk <= 1'h0;
    end else begin
      nc.src_clk <= picked;
    end
  end
endmodule : clk_source_mux
`default_nettype wire

// ---- rtl/clk_net_gate.sv ----
// Falling-edge enable capture and AND gating of one network
`timescale 1ns/10ps
`default_nettype none
`include "clk_ctrl_params.svh"
module clk_net_gate (
  input  wire logic        core_clk, // Core clock
  input  wire logic        rst_b,    // Async reset, active low
  net_ctrl_if.gate_side    nc        // Source level, enable and gated result
);
  import clk_ctrl_pkg::*;

  logic ena_meta;
  logic src_prev;
  logic ena_eff;
  logic src_fall;

  // Extra register for enables driven from another domain; may be skipped
  assign ena_eff  = !nc.gating_ok ? 1'h1 : (nc.bypass ? nc.ena_req : ena_meta);
  assign src_fall = src_prev & ~nc.src_clk;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ena_meta <= `ENA_RESET;
      src_prev <= 1'h0;
    end else begin
      ena_meta <= nc.ena_req;
      src_prev <= nc.src_clk;
    end
  end

  // Enable changes only as the source falls, so a high phase is never cut
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      nc.ena_state <= `ENA_RESET;
    end else if (src_fall) begin
      nc.ena_state <= ena_eff;
    end
  end

  // AND of level and captured enable; power-down holds the network low
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      nc.gated_clk <= 1'h0;
    end else begin
      nc.gated_clk <= nc.src_clk & (nc.ena_state | ~nc.gating_ok) & ~nc.power_down;
    end
  end
endmodule : clk_net_gate
`default_nettype wire

// ---- rtl/clock_network_select_gate.sv ----
// Clock control block for one global, regional or periphery network
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "clk_ctrl_params.svh"
module clock_network_select_gate (
  input  wire logic                  core_clk,              // Core clock, 125 MHz
  input  wire logic                  rst_b,                 // Async reset, active low
  input  wire clk_ctrl_pkg::reg_addr_t reg_addr,            // Register byte address
  input  wire clk_ctrl_pkg::word_t   reg_wdata,             // Register write data
  input  wire logic                  reg_wr,                // Write strobe
  input  wire logic                  reg_rd,                // Read strobe
  output      clk_ctrl_pkg::word_t   reg_rdata,             // Read data, cycle after strobe
  input  wire logic [3:0]            clock_pin,             // Four same-side clock pins
  input  wire logic                  pll_post_counter_zero, // PLL counter 0 output
  input  wire logic                  pll_post_counter_one,  // PLL counter 1 output
  input  wire logic                  pll_post_counter_two,  // PLL counter 2 output
  input  wire logic                  pll_post_counter_three,// PLL counter 3 output
  input  wire logic                  pll_post_counter_four, // PLL counter 4 output
  input  wire logic                  transceiver_output,    // Transceiver clock for periphery
  input  wire logic [1:0]            pll_ext_clk,           // PLL dedicated external clocks
  input  wire clk_ctrl_pkg::mux_sel_t source_select,        // Run-time source index
  input  wire logic                  net_enable,            // Run-time network enable
  input  wire logic                  logic_clk_src,         // Fabric logic clock source
  output logic                       network_clk,           // Gated network clock
  output logic                       dual_network_clk,      // Adjacent regional network
  output logic [1:0]                 ext_clk_out            // External clock output pins
);
  import clk_ctrl_pkg::*;

  // One synchroniser bit per outside source: 4 pins, 5 counters,
  // the transceiver and 2 external clocks
  localparam int SYNC_W = 12;

  // Pick one of four pins by a two-bit index
  // Any pin on this side may feed input zero or one
  function automatic logic pick_pin(input logic [3:0] pins, input logic [1:0] idx);
    pick_pin = pins[idx];
  endfunction : pick_pin

  // Pick between the two counters that may feed one mux input
  function automatic logic pick_counter(input logic use_hi, input logic lo, input logic hi);
    pick_counter = use_hi ? hi : lo;
  endfunction : pick_counter

  // Bundle between this block, the source mux and the gate
  net_ctrl_if nc ();

  // Register state and read path
  word_t              ctrl;
  word_t              status;
  word_t              next_rdata;

  // Synchroniser stages and their groups
  logic [SYNC_W-1:0]  sync_a;
  logic [SYNC_W-1:0]  sync_b;
  logic [SYNC_W-1:0]  async_in;
  logic [3:0]         pin_s;
  logic [4:0]         cnt_s;
  logic               xcvr_s;
  logic [1:0]         ext_s;

  // Fields decoded from the control word
  net_kind_t          kind;
  logic               left_side;
  logic               dyn_sel_on;
  mux_sel_t           static_sel;
  logic               in2_pick;
  logic               in3_pick;
  logic               in_use;
  logic               static_ena;
  logic               dyn_ena_on;
  logic               meta_bypass;
  logic               drives_pll;
  logic               dual_on;
  logic               periph_logic;
  logic [1:0]         ext_en;
  logic [1:0]         pin0_idx;
  logic [1:0]         pin1_idx;

  // Decoded behaviour
  logic               is_periph;
  logic               is_regional;
  logic               is_global;
  logic               dyn_sel_live;
  logic               dyn_ena_live;
  logic [3:0]         net_inclk;
  mux_sel_t           eff_sel;

  // Bus decode
  logic               wr_ctrl;
  logic               rd_ctrl;
  logic               rd_status;

  // Pins and PLL outputs come from other domains and pass two flops
  // Two stages add latency to every source edge; harmless, since sources
  // are only ever seen as levels sampled on core_clk
  assign async_in = {pll_ext_clk, transceiver_output, pll_post_counter_four,
                     pll_post_counter_three, pll_post_counter_two,
                     pll_post_counter_one, pll_post_counter_zero, clock_pin};

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= async_in;
      sync_b <= sync_a;
    end
  end

  // Synchronised groups, read only from the second stage
  assign pin_s  = sync_b[3:0];
  assign cnt_s  = sync_b[8:4];
  assign xcvr_s = sync_b[9];
  assign ext_s  = sync_b[11:10];

  // Control word fields
  assign kind         = net_kind_t'(ctrl[`KIND_LSB +: 2]);
  assign left_side    = ctrl[`LEFT_BIT];
  assign dyn_sel_on   = ctrl[`DYNSEL_BIT];
  assign static_sel   = ctrl[`SSEL_LSB +: 2];
  assign in2_pick     = ctrl[`IN2_PICK_BIT];
  assign in3_pick     = ctrl[`IN3_PICK_BIT];
  assign in_use       = ctrl[`INUSE_BIT];
  assign static_ena   = ctrl[`SENA_BIT];
  assign dyn_ena_on   = ctrl[`DYNENA_BIT];
  assign meta_bypass  = ctrl[`BYPASS_BIT];
  assign drives_pll   = ctrl[`DRVPLL_BIT];
  assign dual_on      = ctrl[`DUAL_BIT];
  assign periph_logic = ctrl[`PSRC_BIT];
  assign ext_en       = ctrl[`EXTEN_LSB +: 2];
  assign pin0_idx     = ctrl[`PIN0_LSB +: 2];
  assign pin1_idx     = ctrl[`PIN1_LSB +: 2];

  // Network kind decode; the reserved code behaves as periphery
  // Treating it as periphery keeps an unset kind from gating by accident
  assign is_periph = (kind == KIND_PERIPH) || (kind == KIND_RSVD);
  assign is_global = (kind == KIND_GLOBAL);
  assign is_regional = (kind == KIND_REGIONAL);

  // Run-time select lives only on global networks
  assign dyn_sel_live = is_global & dyn_sel_on;

  // Run-time enable is refused on periphery and on PLL-feeding networks
  // Gating a PLL input would make that PLL lose lock
  assign dyn_ena_live = dyn_ena_on & ~is_periph & ~drives_pll;

  // Mux inputs: pins on 0 and 1, counters on 2 and 3, left side differs.
  // Periphery reuses inputs 0 and 1 for transceiver and fabric logic.
  always_comb begin
    net_inclk = 4'h0;
    if (is_periph) begin
      net_inclk[0] = xcvr_s;
      net_inclk[1] = logic_clk_src;
    end else begin
      net_inclk[0] = pick_pin(pin_s, pin0_idx);
      net_inclk[1] = pick_pin(pin_s, pin1_idx);
      // Left blocks see only counter four; input three stays low
      if (left_side) begin
        net_inclk[2] = cnt_s[4];
        net_inclk[3] = 1'h0;
      end else begin
        // Other sides choose each input from a pair of counters
        net_inclk[2] = pick_counter(in2_pick, cnt_s[0], cnt_s[2]);
        net_inclk[3] = pick_counter(in3_pick, cnt_s[1], cnt_s[3]);
      end
    end
  end

  // Effective source index: fabric index or the configured one
  // Periphery reuses the index: 0 picks the transceiver, 1 fabric logic
  always_comb begin
    if (is_periph) begin
      eff_sel = {1'h0, periph_logic};
    end else if (dyn_sel_live) begin
      eff_sel = source_select;
    end else begin
      eff_sel = static_sel;
    end
  end

  // Drive the shared interface toward mux and gate
  // Periphery never gates: gating_ok low makes the gate ignore the enable
  assign nc.inclk      = net_inclk;
  assign nc.sel        = eff_sel;
  assign nc.ena_req    = static_ena & (dyn_ena_live ? net_enable : 1'h1);
  assign nc.bypass     = meta_bypass;
  assign nc.gating_ok  = ~is_periph;
  assign nc.power_down = ~in_use;

  // Source mux; a select change shows one cycle later
  clk_source_mux u_mux (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .nc       (nc.sel_side)
  );

  // Gate with falling-edge enable capture and power-down
  clk_net_gate u_gate (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .nc       (nc.gate_side)
  );

  // Network outputs. PLL counters are only ever observed here, never stopped,
  // so a gated network leaves the PLL locked.
  assign network_clk = nc.gated_clk;

  // Dual-regional copy; only regional networks may pair up
  // Shares the main captured enable, so both halves of the region switch
  // on the same falling edge
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dual_network_clk <= 1'h0;
    end else begin
      dual_network_clk <= is_regional & dual_on & nc.src_clk & nc.ena_state
                          & in_use;
    end
  end

  // External PLL outputs: individual enables plus the network gate
  // Not held by the in-use bit: these belong to the PLL, not this network
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_clk_out <= 2'h0;
    end else begin
      ext_clk_out <= ext_s & ext_en & {2{nc.ena_state}};
    end
  end

  // Register decode; reads decode without a strobe, which only decides
  // whether the result is registered
  assign wr_ctrl   = reg_wr & (reg_addr == `CTRL_OFS);
  assign rd_ctrl   = reg_addr == `CTRL_OFS;
  assign rd_status = reg_addr == `STATUS_OFS;

  // Status word shows the block's live state
  // The level bit is the registered gate output, one cycle old at the read
  always_comb begin
    status                       = '0;
    status[`ST_SEL_LSB +: 2]     = eff_sel;
    status[`ST_ENA_BIT]          = nc.ena_state;
    status[`ST_ACTIVE_BIT]       = in_use;
    status[`ST_LEVEL_BIT]        = nc.gated_clk;
    status[`ST_DYNSEL_BIT]       = dyn_sel_live;
    status[`ST_DYNENA_BIT]       = dyn_ena_live;
  end

  // Unmapped addresses read as zero
  always_comb begin
    if (rd_ctrl) begin
      next_rdata = ctrl;
    end else if (rd_status) begin
      next_rdata = status;
    end else begin
      next_rdata = '0;
    end
  end

  // Control register; bits outside the mask stay zero
  // A new kind or source reaches the network after the mux and gate stages
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= `CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= reg_wdata & `CTRL_MASK;
    end
  end

  // Read data stands only in the cycle after the strobe
  // Returning to zero between reads keeps stale words off the bus
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule : clock_network_select_gate
`default_nettype wire

// ---- verification/clock_network_select_gate_monitor.sv ----
// Checker on the ports of the clock network select and gate block
`timescale 1ns/10ps
`default_nettype none
`include "clk_ctrl_params.svh"
module clock_network_select_gate_monitor (
  input wire logic                    core_clk,              // Clock
  input wire logic                    rst_b,                 // Reset
  input wire clk_ctrl_pkg::reg_addr_t reg_addr,              // Address
  input wire clk_ctrl_pkg::word_t     reg_wdata,             // Write data
  input wire logic                    reg_wr,                // Write strobe
  input wire logic                    reg_rd,                // Read strobe
  input wire clk_ctrl_pkg::word_t     reg_rdata,             // Read data
  input wire logic [3:0]              clock_pin,             // Pins
  input wire logic                    pll_post_counter_zero, // Counter 0
  input wire logic                    pll_post_counter_one,  // Counter 1
  input wire logic                    pll_post_counter_two,  // Counter 2
  input wire logic                    pll_post_counter_three,// Counter 3
  input wire logic                    pll_post_counter_four, // Counter 4
  input wire logic                    transceiver_output,    // Periphery source
  input wire logic [1:0]              pll_ext_clk,           // External sources
  input wire logic                    logic_clk_src,         // Fabric source
  input wire logic                    network_clk,           // Network clock
  input wire logic                    dual_network_clk,      // Adjacent copy
  input wire logic [1:0]              ext_clk_out            // External outputs
);
  import clk_ctrl_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Any source high; the network may only be high a few edges after one
  wire logic any_src = |clock_pin | pll_post_counter_zero | pll_post_counter_one |
    pll_post_counter_two | pll_post_counter_three | pll_post_counter_four |
    transceiver_output | logic_clk_src;

  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not idle");
  a_unmapped_zero: assert property (reg_rd && reg_addr != `CTRL_OFS &&
    reg_addr != `STATUS_OFS |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
  a_status_upper: assert property (reg_rd && reg_addr == `STATUS_OFS
    |=> reg_rdata[31:7] == 25'h0) else $error("status upper bits set");
  a_ctrl_readback: assert property (reg_wr && reg_addr == `CTRL_OFS ##1
    reg_rd && reg_addr == `CTRL_OFS |=> reg_rdata == ($past(reg_wdata, 2) & `CTRL_MASK))
    else $error("control readback wrong");
  a_clk_source: assert property (network_clk |-> $past(any_src, 2) ||
    $past(any_src, 3) || $past(any_src, 4)) else $error("network high without source");
  a_ext_source: assert property ((ext_clk_out & ~($past(pll_ext_clk, 2) |
    $past(pll_ext_clk, 3) | $past(pll_ext_clk, 4))) == 2'h0) else $error("stray ext out");
  a_power_quiet: assert property (reg_wr && reg_addr == `CTRL_OFS &&
    !reg_wdata[`INUSE_BIT] |-> ##[1:4] !network_clk) else $error("powered down net runs");
  a_dual_copy: assert property (dual_network_clk |-> network_clk)
    else $error("dual network without main");

  // Main scenarios reached
  c_net_running: cover property ($rose(network_clk));
  c_dual_live: cover property (dual_network_clk);
  c_ext_both: cover property (ext_clk_out == 2'h3);
endmodule : clock_network_select_gate_monitor

bind clock_network_select_gate clock_network_select_gate_monitor mon (
  .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .clock_pin(clock_pin),
  .pll_post_counter_zero(pll_post_counter_zero), .pll_post_counter_one(pll_post_counter_one),
  .pll_post_counter_two(pll_post_counter_two), .pll_post_counter_three(pll_post_counter_three),
  .pll_post_counter_four(pll_post_counter_four), .transceiver_output(transceiver_output),
  .pll_ext_clk(pll_ext_clk), .logic_clk_src(logic_clk_src), .network_clk(network_clk),
  .dual_network_clk(dual_network_clk), .ext_clk_out(ext_clk_out)
);
`default_nettype wire

// ---- verification/fabric_ctrl_model.sv ----
// Fabric logic model driving source select and run-time enable
`timescale 1ns/10ps
`default_nettype none
module fabric_ctrl_model (
  input  wire logic                   core_clk,      // Clock
  input  wire logic                   rst_b,         // Reset
  input  wire clk_ctrl_pkg::mux_sel_t want_sel,      // Index asked for
  input  wire logic                   want_ena,      // Enable asked for
  input  wire logic                   slow,          // Answer a cycle late
  output var  clk_ctrl_pkg::mux_sel_t source_select, // Two-bit index
  output var  logic                   net_enable     // Run-time enable
);
  import clk_ctrl_pkg::*;
  mux_sel_t sel_d;
  logic     ena_d;
  // Registered like real fabric; slow mode adds one stage of latency
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_d <= 2'h0;
      ena_d <= 1'h1;
      source_select <= 2'h0;
      net_enable <= 1'h1;
    end else begin
      sel_d <= want_sel;
      ena_d <= want_ena;
      source_select <= slow ? sel_d : want_sel;
      net_enable <= slow ? ena_d : want_ena;
    end
  end
endmodule : fabric_ctrl_model
`default_nettype wire

// ---- verification/clock_network_select_gate_test.sv ----
// Self-checking bench for the clock network select and gate block
`timescale 1ns/10ps
`default_nettype none
`include "clk_ctrl_params.svh"
module clock_network_select_gate_test;
  import clk_ctrl_pkg::*;
  logic       core_clk = 1'h0;
  logic       rst_b = 1'h0;
  reg_addr_t  reg_addr = 4'h0;
  word_t      reg_wdata = 32'h0;
  logic       reg_wr = 1'h0;
  logic       reg_rd = 1'h0;
  logic [3:0] clock_pin = 4'h0;
  logic [4:0] cnt = 5'h0;
  logic       transceiver_output = 1'h0;
  logic [1:0] pll_ext_clk = 2'h0;
  logic       logic_clk_src = 1'h0;
  mux_sel_t   want_sel = 2'h0;
  logic       want_ena = 1'h1;
  logic       slow = 1'h0;
  mux_sel_t   source_select;
  logic       net_enable, network_clk, dual_network_clk, e_net;
  logic [1:0] ext_clk_out;
  word_t      reg_rdata, c, d;
  int         num_errors = 0;
  int         check_count = 0;
  int         h;

  clock_network_select_gate dut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .clock_pin(clock_pin), .pll_post_counter_zero(cnt[0]), .pll_post_counter_one(cnt[1]),
    .pll_post_counter_two(cnt[2]), .pll_post_counter_three(cnt[3]),
    .pll_post_counter_four(cnt[4]), .transceiver_output(transceiver_output),
    .pll_ext_clk(pll_ext_clk), .source_select(source_select), .net_enable(net_enable),
    .logic_clk_src(logic_clk_src), .network_clk(network_clk),
    .dual_network_clk(dual_network_clk), .ext_clk_out(ext_clk_out));
  fabric_ctrl_model fabric (.core_clk(core_clk), .rst_b(rst_b), .want_sel(want_sel),
    .want_ena(want_ena), .slow(slow), .source_select(source_select), .net_enable(net_enable));

  // 125 MHz core clock
  always #4 core_clk = ~core_clk;

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Bus cycles start just after a rising edge and end on one
  task automatic wr(input reg_addr_t a, input word_t v);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask : wr

  task automatic rd(input reg_addr_t a, output word_t v);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1 v = reg_rdata;
    @(posedge core_clk);
  endtask : rd

  // Square wave on pin 0 and fabric source; counts late network highs only
  task automatic toggle(output int n_high);
    n_high = 0;
    for (int n = 0; n < 24; n++) begin
      clock_pin[0] <= n[1];
      logic_clk_src <= n[1];
      @(negedge core_clk);
      if (n >= 12 && network_clk === 1'h1) n_high++;
      @(posedge core_clk);
    end
  endtask : toggle

  // Expected settled network level with the enable held on
  function automatic logic exp_net(word_t k, mux_sel_t s, logic [3:0] p, logic [4:0] q,
                                   logic x, logic l);
    logic [3:0] mux_in;
    mux_sel_t   e;
    mux_in = {k[`LEFT_BIT] ? 1'h0 : (k[`IN3_PICK_BIT] ? q[3] : q[1]),
              k[`LEFT_BIT] ? q[4] : (k[`IN2_PICK_BIT] ? q[2] : q[0]),
              p[k[`PIN1_LSB +: 2]], p[k[`PIN0_LSB +: 2]]};
    e = (k[1:0] == KIND_GLOBAL && k[`DYNSEL_BIT]) ? s : k[`SSEL_LSB +: 2];
    if (!k[`INUSE_BIT]) return 1'h0;
    if (k[1]) return k[`PSRC_BIT] ? l : x;
    return mux_in[e];
  endfunction : exp_net

  // Expected mux index: periphery by its source bit, global may follow fabric
  function automatic mux_sel_t exp_sel(word_t k, mux_sel_t s);
    if (k[1]) return {1'h0, k[`PSRC_BIT]};
    return (k[1:0] == KIND_GLOBAL && k[`DYNSEL_BIT]) ? s : k[`SSEL_LSB +: 2];
  endfunction : exp_sel

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report

  initial begin
    void'($urandom(32'hEB0E_269A));
    repeat (4) @(posedge core_clk);
    rst_b <= 1'h1;
    @(posedge core_clk);
    // Status write refused, reset values, unmapped read, writable mask
    wr(`STATUS_OFS, 32'hFFFF_FFFF);
    rd(`CTRL_OFS, d);
    chk("ctrl reset", d, `CTRL_RESET);
    rd(`STATUS_OFS, d);
    chk("enable after reset", 32'(d[`ST_ENA_BIT]), 32'h1);
    rd(4'h8, d);
    chk("unmapped read", d, 32'h0);
    wr(`CTRL_OFS, 32'hFFFF_FFFF);
    rd(`CTRL_OFS, d);
    chk("ctrl mask", d, `CTRL_MASK);
    $display("register test done");
    // Random sources and settings; first four sweep every index on a left block
    for (int i = 0; i < 40; i++) begin
      c = $urandom & `CTRL_MASK;
      c[`SENA_BIT] = 1'h1;
      c[`DYNENA_BIT] = 1'h0;
      if (i < 4) c[3:0] = 4'hC;
      if (i < 4) c[`INUSE_BIT] = 1'h1;
      if (c[1:0] != KIND_REGIONAL) c[`DUAL_BIT] = 1'h0;
      {clock_pin, cnt, transceiver_output, logic_clk_src, pll_ext_clk} <=
        (i < 4) ? 13'h1FFF : 13'($urandom);
      want_sel <= (i < 4) ? 2'(i) : 2'($urandom);
      slow <= 1'($urandom);
      wr(`CTRL_OFS, c);
      repeat (8) @(posedge core_clk);
      @(negedge core_clk);
      e_net = exp_net(c, want_sel, clock_pin, cnt, transceiver_output, logic_clk_src);
      chk("network_clk", 32'(network_clk), 32'(e_net));
      chk("dual_network_clk", 32'(dual_network_clk), 32'(c[`DUAL_BIT] & e_net));
      chk("ext_clk_out", 32'(ext_clk_out), 32'(pll_ext_clk & c[`EXTEN_LSB +: 2]));
      @(posedge core_clk);
      rd(`STATUS_OFS, d);
      chk("status select", 32'(d[`ST_SEL_LSB +: 2]), 32'(exp_sel(c, want_sel)));
      chk("status in use", 32'(d[`ST_ACTIVE_BIT]), 32'(c[`INUSE_BIT]));
      chk("status level", 32'(d[`ST_LEVEL_BIT]), 32'(e_net));
      chk("dynsel", 32'(d[`ST_DYNSEL_BIT]), 32'(c[1:0] == 2'h0 && c[`DYNSEL_BIT]));
    end
    $display("source test done");
    // Run-time disable: honoured, refused on a PLL feed, absent on periphery
    for (int j = 0; j < 3; j++) begin
      c = `CTRL_RESET | (32'h1 << `DYNENA_BIT) | (32'($urandom_range(1)) << `BYPASS_BIT);
      if (j == 1) c[`DRVPLL_BIT] = 1'h1;
      if (j == 2) c = c | 32'h0000_4002;
      want_ena <= 1'h0;
      wr(`CTRL_OFS, c);
      toggle(h);
      chk("gated highs", 32'(h != 0), 32'(j != 0));
      rd(`STATUS_OFS, d);
      chk("captured enable", 32'(d[`ST_ENA_BIT]), 32'(j != 0));
      chk("dynena live", 32'(d[`ST_DYNENA_BIT]), 32'(j == 0));
      want_ena <= 1'h1;
      toggle(h);
      chk("restored highs", 32'(h != 0), 32'h1);
    end
    $display("enable test done");
    final_report();
  end
endmodule : clock_network_select_gate_test
`default_nettype wire
